// ---- common/serial_bus_pkg.sv ----
// Shared constants and types for the two-wire serial bus master
package serial_bus_pkg;
   // Link clock rate and bit timing (four quarters per SCL period)
   localparam int LINK_PERIOD_PS = 6000;
   localparam int SCL_QUARTER_NS = 2500;
   localparam int QTR_CYC = (SCL_QUARTER_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam logic [9:0] QTR_LAST = 10'(QTR_CYC - 1);
   localparam logic [10:0] HIGH_MIN = 11'(2 * QTR_CYC - 1);
   // Settling time for strap inputs after reset release
   localparam logic [2:0] STRAP_WAIT = 3'h4;
   // EEPROM map
   localparam logic [6:0] EEPROM_ADDR = 7'h50;
   localparam logic [7:0] FLAG_OFFSET = 8'h00;
   localparam logic [7:0] FLAG_LOAD = 8'h01;
   localparam logic [7:0] LAST_OFFSET = 8'h18;
   localparam logic [7:0] OFFSET_STEP = 8'h04;
   // Byte slots inside one transaction
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [2:0] BYTE_ADDR = 3'h0;
   localparam logic [2:0] BYTE_INDEX = 3'h1;
   localparam logic [2:0] BYTE_WDATA = 3'h2;
   localparam logic [2:0] BYTE_RADDR = 3'h2;
   localparam logic [2:0] BYTE_RDATA = 3'h3;
   localparam logic [2:0] BYTE_DLAST = 3'h6;
   typedef enum logic [1:0] {OP_WRITE = 2'h1, OP_READ = 2'h2, OP_DWORD = 2'h3} op_t;
   typedef enum logic [4:0] {
      L_IDLE = 5'h01, L_START = 5'h02, L_BIT = 5'h04, L_RSTART = 5'h08, L_STOP = 5'h10
   } link_state_t;
   typedef enum logic [4:0] {
      M_STRAP = 5'h01, M_IDLE = 5'h02, M_INIT_REQ = 5'h04, M_INIT_WAIT = 5'h08, M_SW_WAIT = 5'h10
   } ctrl_state_t;
endpackage : serial_bus_pkg

// ---- verilog/sync_two_stage.sv ----
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/10ps
module sync_two_stage #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] hold_r;

   // First stage feeds only the second
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         meta_r <= '0;
         hold_r <= '0;
      end
      else
      begin
         meta_r <= d_in;
         hold_r <= meta_r;
      end
   end

   assign q_out = hold_r;
endmodule : sync_two_stage

// ---- verilog/serial_bus_master.sv ----
// Two-wire serial bus master with EEPROM default loader
// Summary of operation
// [RL1] Both power-switch pins pulled up at reset: set bus detect flag.
// [RL2] Writing one to the detect flag clears it; zero leaves it.
// [RL3] Once detected, SCL uses multifunction pin four, SDA pin one.
// [RL4] SCL toggles near 100 kHz during transfers.
// [RL5] Board places the EEPROM at bus address A0h.
// [RL6] Both lines are open drain: pull low or release only.
// [RL7] Standard-mode master, 7-bit addressing, at most 100 kb/s.
// [RL8] Each transfer starts with SDA falling while SCL is high.
// [RL9] Each transfer ends with SDA rising while SCL is high.
// [RL10] SDA changes only while SCL is low, except start and stop.
// [RL11] Data moves in 8-bit bytes, each followed by an acknowledge bit.
// [RL12] Receiver acknowledges by holding SDA low on the ninth clock high.
// [RL13] Byte count per transfer is unlimited by the protocol.
// [RL14] Only master; SCL released with no clocking when idle.
// [RL15] Software may start only single-byte reads and writes.
// [RL16] Doubleword reads come only from the loader after reset.
// [RL17] Write: start, address+0, ack, index, ack, data MSB first, ack, stop.
// [RL18] A missing slave acknowledge sets the error flag.
// [RL19] A read sends the slave address with direction bit one.
// [RL20] Slave drives read data; master clocks and acknowledges each byte.
// [RL21] Software start strobe with address and direction begins a transaction.
// [RL22] Index value is sent as the word address in software transfers.
// [RL23] The loader addresses the EEPROM at 1010000b.
// [RL24] Loader reads flag at offset 00h; loads only when it is 01h.
// [RL25] Read: write word address, repeated start, address with read.
`timescale 1ns/10ps
module serial_bus_master
   import serial_bus_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        link_clk_in,
   input  wire logic        power_switch_ctrl_zero_in,
   input  wire logic        power_switch_ctrl_one_in,
   input  wire logic        multifunction_pin_four_in,
   output logic             multifunction_pin_four_out,
   output logic             multifunction_pin_four_oe_out,
   input  wire logic        multifunction_pin_one_in,
   output logic             multifunction_pin_one_out,
   output logic             multifunction_pin_one_oe_out,
   input  wire logic        sw_start_in,
   input  wire logic [6:0]  sw_slave_addr_in,
   input  wire logic        sw_read_in,
   input  wire logic [7:0]  sw_index_in,
   input  wire logic [7:0]  sw_wdata_in,
   input  wire logic        detect_clear_in,
   input  wire logic        error_clear_in,
   output logic [7:0]       sw_rdata_out,
   output logic             rdata_valid_out,
   output logic             busy_out,
   output logic             error_out,
   output logic             bus_detect_flag_out,
   output logic             load_valid_out,
   output logic [7:0]       load_offset_out,
   output logic [31:0]      load_data_out
);
   // Controller clock domain state
   ctrl_state_t mst_r, mst_nxt;
   logic [2:0]  strap_cnt_r;
   logic        present_r, detect_r, error_r, busy_r;
   logic        req_tgl_r, done_seen_r, flag_ok_r;
   op_t         op_r;
   logic [6:0]  addr_r;
   logic [7:0]  index_r, wdata_r, init_off_r, rdata_r;
   logic        rdata_valid_r, load_valid_r;
   logic [7:0]  load_off_r;
   logic [31:0] load_data_r;
   logic        psz_s, pso_s, done_s;

   // Link clock domain state
   link_state_t lst_r;
   logic [1:0]  phase_r;
   logic [9:0]  qcnt_r;
   logic [10:0] hi_cnt_r;
   logic [3:0]  bit_cnt_r;
   logic [2:0]  byte_num_r;
   logic [7:0]  shift_r;
   logic [31:0] rx_word_r;
   logic        nack_r, scl_oe_r, sda_oe_r, pin_low_r;
   logic        req_seen_r, done_tgl_r;
   op_t         lop_r;
   logic [6:0]  laddr_r;
   logic [7:0]  lindex_r, lwdata_r;
   logic        link_rst, req_s, scl_s, sda_s;

   // Crossings into the controller domain
   sync_two_stage #(.WIDTH(3)) u_sync_m (
      .clk_in (mclk_in),
      .rst_in (rst_in),
      .d_in   ({power_switch_ctrl_zero_in, power_switch_ctrl_one_in, done_tgl_r}),
      .q_out  ({psz_s, pso_s, done_s})
   );

   // Reset carried into the link domain
   sync_two_stage #(.WIDTH(1)) u_sync_rst (
      .clk_in (link_clk_in),
      .rst_in (1'b0),
      .d_in   (rst_in),
      .q_out  (link_rst)
   );

   // Crossings into the link domain
   sync_two_stage #(.WIDTH(3)) u_sync_l (
      .clk_in (link_clk_in),
      .rst_in (link_rst),
      .d_in   ({req_tgl_r, multifunction_pin_four_in, multifunction_pin_one_in}),
      .q_out  ({req_s, scl_s, sda_s})
   );

   // Controller decode
   wire strap_done = (strap_cnt_r == STRAP_WAIT);
   wire detect_set = (mst_r == M_STRAP) && strap_done && psz_s && pso_s; // RL1
   wire done_ev    = done_s ^ done_seen_r;
   wire sw_go      = (mst_r == M_IDLE) && sw_start_in && present_r; // RL21
   wire init_done  = (mst_r == M_INIT_WAIT) && done_ev;
   wire sw_done    = (mst_r == M_SW_WAIT) && done_ev;
   wire flag_ok    = (rx_word_r[7:0] == FLAG_LOAD);
   wire at_flag    = (init_off_r == FLAG_OFFSET);
   wire init_good  = init_done && !nack_r && (!at_flag || flag_ok); // RL24
   wire err_set    = (init_done || sw_done) && nack_r; // RL18

   // Controller sequencing: strap, EEPROM load, software transfers
   always_comb
   begin
      mst_nxt = mst_r;
      case (mst_r)
         M_STRAP:     if (strap_done) mst_nxt = (psz_s && pso_s) ? M_INIT_REQ : M_IDLE;
         M_INIT_REQ:  mst_nxt = M_INIT_WAIT;
         M_INIT_WAIT: if (done_ev) mst_nxt = (init_good && init_off_r != LAST_OFFSET) ? M_INIT_REQ : M_IDLE;
         M_IDLE:      if (sw_go) mst_nxt = M_SW_WAIT;
         M_SW_WAIT:   if (done_ev) mst_nxt = M_IDLE;
         default:     mst_nxt = M_IDLE;
      endcase
   end

   // Controller state and status flags; a set wins over a clear
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         mst_r       <= M_STRAP;
         strap_cnt_r <= 3'h0;
         present_r   <= 1'b0;
         detect_r    <= 1'b0;
         error_r     <= 1'b0;
         busy_r      <= 1'b0;
         done_seen_r <= 1'b0;
      end
      else
      begin
         mst_r       <= mst_nxt;
         strap_cnt_r <= strap_done ? strap_cnt_r : strap_cnt_r + 3'h1;
         present_r   <= present_r | detect_set; // RL3
         detect_r    <= detect_set | (detect_r & ~detect_clear_in); // RL2
         error_r     <= err_set | (error_r & ~error_clear_in); // RL18
         busy_r      <= (mst_nxt != M_IDLE);
         done_seen_r <= done_s;
      end
   end

   // Transaction descriptor, held stable while the link works on it
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         req_tgl_r <= 1'b0;
         op_r      <= OP_WRITE;
         addr_r    <= 7'h00;
         index_r   <= 8'h00;
         wdata_r   <= 8'h00;
      end
      else if (mst_r == M_INIT_REQ)
      begin
         req_tgl_r <= ~req_tgl_r;
         op_r      <= OP_DWORD; // RL16
         addr_r    <= EEPROM_ADDR; // RL23
         index_r   <= init_off_r;
      end
      else if (sw_go)
      begin
         req_tgl_r <= ~req_tgl_r;
         op_r      <= sw_read_in ? OP_READ : OP_WRITE; // RL15
         addr_r    <= sw_slave_addr_in; // RL7
         index_r   <= sw_index_in; // RL22
         wdata_r   <= sw_wdata_in;
      end
   end

   // Results: loaded defaults and software read data
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         init_off_r    <= FLAG_OFFSET;
         flag_ok_r     <= 1'b0;
         load_valid_r  <= 1'b0;
         load_off_r    <= 8'h00;
         load_data_r   <= 32'h0000_0000;
         rdata_r       <= 8'h00;
         rdata_valid_r <= 1'b0;
      end
      else
      begin
         load_valid_r <= init_good; // RL24
         if (init_good)
         begin
            init_off_r  <= init_off_r + OFFSET_STEP;
            flag_ok_r   <= 1'b1;
            load_off_r  <= init_off_r;
            load_data_r <= rx_word_r;
         end
         if (sw_go)
            rdata_valid_r <= 1'b0;
         else if (sw_done && op_r == OP_READ && !nack_r)
         begin
            rdata_r       <= rx_word_r[31:24];
            rdata_valid_r <= 1'b1;
         end
      end
   end

   // Link decode
   wire req_ev     = req_s ^ req_seen_r;
   wire stretch    = !scl_oe_r && !scl_s;
   wire tick       = (qcnt_r == QTR_LAST) && !stretch; // RL4
   wire is_write   = (lop_r == OP_WRITE);
   wire is_rx      = !is_write && (byte_num_r >= BYTE_RDATA);
   wire ack_slot   = (bit_cnt_r == ACK_BIT);
   wire last_byte  = is_write ? (byte_num_r == BYTE_WDATA) :
                     (lop_r == OP_READ) ? (byte_num_r == BYTE_RDATA) : (byte_num_r == BYTE_DLAST);
   wire [7:0] tx_byte = (byte_num_r == BYTE_ADDR)  ? {laddr_r, 1'b0} : // RL17
                        (byte_num_r == BYTE_INDEX) ? lindex_r :
                        is_write ? lwdata_r : {laddr_r, 1'b1}; // RL19
   wire [7:0] shift_src = (bit_cnt_r == 4'h0) ? tx_byte : shift_r;
   wire bit_drive  = ack_slot ? is_rx : (!is_rx && !shift_src[7]); // RL12
   wire nack_now   = (lst_r == L_BIT) && tick && (phase_r == 2'h2) && ack_slot && !is_rx && sda_s;
   wire [2:0] byte_inc = byte_num_r + 3'h1;

   // Quarter-bit timer, held while a slave stretches SCL low
   always_ff @(posedge link_clk_in)
   begin
      if (link_rst || lst_r == L_IDLE || tick)
         qcnt_r <= 10'h000;
      else if (!stretch)
         qcnt_r <= qcnt_r + 10'h001;
   end

   // Time SCL has been released, used to check the high phase
   always_ff @(posedge link_clk_in)
   begin
      if (link_rst || scl_oe_r)
         hi_cnt_r <= 11'h000;
      else if (hi_cnt_r != 11'h7FF)
         hi_cnt_r <= hi_cnt_r + 11'h001;
   end

   // Link engine: start, bytes with acknowledge, repeated start, stop
   always_ff @(posedge link_clk_in)
   begin
      if (link_rst)
      begin
         lst_r      <= L_IDLE;
         phase_r    <= 2'h0;
         bit_cnt_r  <= 4'h0;
         byte_num_r <= 3'h0;
         shift_r    <= 8'h00;
         rx_word_r  <= 32'h0000_0000;
         nack_r     <= 1'b0;
         scl_oe_r   <= 1'b0;
         sda_oe_r   <= 1'b0;
         pin_low_r  <= 1'b0;
         req_seen_r <= 1'b0;
         done_tgl_r <= 1'b0;
         lop_r      <= OP_WRITE;
         laddr_r    <= 7'h00;
         lindex_r   <= 8'h00;
         lwdata_r   <= 8'h00;
      end
      else
      begin
         pin_low_r <= 1'b0; // RL6
         if (tick)
            phase_r <= phase_r + 2'h1;
         case (lst_r)
            L_IDLE:
            begin
               scl_oe_r <= 1'b0; // RL14
               sda_oe_r <= 1'b0;
               phase_r  <= 2'h0;
               if (req_ev)
               begin
                  req_seen_r <= req_s;
                  lop_r      <= op_r;
                  laddr_r    <= addr_r;
                  lindex_r   <= index_r;
                  lwdata_r   <= wdata_r;
                  byte_num_r <= BYTE_ADDR;
                  nack_r     <= 1'b0;
                  lst_r      <= L_START;
               end
            end
            L_START:
               if (tick)
               begin
                  if (phase_r == 2'h0) sda_oe_r <= 1'b1; // RL8
                  if (phase_r == 2'h2) scl_oe_r <= 1'b1;
                  if (phase_r == 2'h3)
                  begin
                     bit_cnt_r <= 4'h0;
                     lst_r     <= L_BIT;
                  end
               end
            L_BIT:
               if (tick)
               begin
                  if (phase_r == 2'h0) sda_oe_r <= bit_drive; // RL10
                  if (phase_r == 2'h1) scl_oe_r <= 1'b0;
                  if (phase_r == 2'h2 && !ack_slot) shift_r <= {shift_src[6:0], sda_s}; // RL11
                  if (nack_now) nack_r <= 1'b1; // RL18
                  if (phase_r == 2'h3)
                  begin
                     scl_oe_r <= 1'b1;
                     if (!ack_slot)
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                     else
                     begin
                        bit_cnt_r <= 4'h0;
                        if (is_rx) rx_word_r <= {shift_r, rx_word_r[31:8]}; // RL20
                        if (nack_r || last_byte)
                           lst_r <= L_STOP;
                        else if (!is_write && byte_num_r == BYTE_INDEX)
                           lst_r <= L_RSTART; // RL25
                        else
                           byte_num_r <= byte_inc; // RL13
                     end
                  end
               end
            L_RSTART:
               if (tick)
               begin
                  if (phase_r == 2'h0) sda_oe_r <= 1'b0;
                  if (phase_r == 2'h1) scl_oe_r <= 1'b0;
                  if (phase_r == 2'h2) sda_oe_r <= 1'b1; // RL25
                  if (phase_r == 2'h3)
                  begin
                     scl_oe_r   <= 1'b1;
                     byte_num_r <= byte_inc;
                     lst_r      <= L_BIT;
                  end
               end
            L_STOP:
               if (tick)
               begin
                  if (phase_r == 2'h0) sda_oe_r <= 1'b1;
                  if (phase_r == 2'h1) scl_oe_r <= 1'b0;
                  if (phase_r == 2'h2) sda_oe_r <= 1'b0; // RL9
                  if (phase_r == 2'h3)
                  begin
                     done_tgl_r <= ~done_tgl_r;
                     lst_r      <= L_IDLE;
                  end
               end
            default: lst_r <= L_IDLE;
         endcase
      end
   end

   // Outputs straight from flip-flops; pins only ever pull low
   assign multifunction_pin_four_out    = pin_low_r;
   assign multifunction_pin_four_oe_out = scl_oe_r; // RL3
   assign multifunction_pin_one_out     = pin_low_r;
   assign multifunction_pin_one_oe_out  = sda_oe_r; // RL3
   assign sw_rdata_out        = rdata_r;
   assign rdata_valid_out     = rdata_valid_r;
   assign busy_out            = busy_r;
   assign error_out           = error_r;
   assign bus_detect_flag_out = detect_r;
   assign load_valid_out      = load_valid_r;
   assign load_offset_out     = load_off_r;
   assign load_data_out       = load_data_r;

   // Controller domain checks
   detect_rise_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL1
      $rose(detect_r) |-> present_r && $past(psz_s) && $past(pso_s))
      else $error("detect flag set without both pullups");
   detect_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL2
      (detect_r && detect_clear_in && !detect_set) |=> !detect_r)
      else $error("detect flag not cleared by write of one");
   init_target_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL23
      (mst_r == M_INIT_REQ) |=> (op_r == OP_DWORD && addr_r == EEPROM_ADDR && index_r == $past(init_off_r)))
      else $error("loader read not aimed at EEPROM");
   sw_single_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL15
      (mst_r == M_SW_WAIT) |-> (op_r != OP_DWORD))
      else $error("software transfer used doubleword read");
   load_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL24
      load_valid_r |-> flag_ok_r && (!$past(at_flag) || $past(rx_word_r[7:0]) == FLAG_LOAD))
      else $error("defaults loaded without load flag");
   nack_error_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL18
      (done_ev && nack_r && mst_r == M_SW_WAIT) |=> error_r)
      else $error("missing acknowledge not flagged");

   // Link domain checks
   sequence s_ack_drive;
      (lst_r == L_BIT) && ack_slot && is_rx && (phase_r != 2'h0);
   endsequence
   sequence s_scl_drop;
      $rose(scl_oe_r) && ($past(lst_r) == L_BIT);
   endsequence
   scl_idle_a: assert property (@(posedge link_clk_in) disable iff (link_rst) // RL14
      (lst_r == L_IDLE) |=> !scl_oe_r)
      else $error("SCL driven while idle");
   start_cond_a: assert property (@(posedge link_clk_in) disable iff (link_rst) // RL8
      ($rose(sda_oe_r) && !scl_oe_r) |-> (lst_r == L_START || lst_r == L_RSTART))
      else $error("SDA fell with SCL high outside start");
   stop_cond_a: assert property (@(posedge link_clk_in) disable iff (link_rst) // RL9
      ($fell(sda_oe_r) && !scl_oe_r) |-> (lst_r == L_STOP))
      else $error("SDA rose with SCL high outside stop");
   sda_stable_a: assert property (@(posedge link_clk_in) disable iff (link_rst) // RL10
      ((lst_r == L_BIT) && $changed(sda_oe_r)) |-> scl_oe_r)
      else $error("SDA changed during SCL high");
   scl_high_a: assert property (@(posedge link_clk_in) disable iff (link_rst) // RL4
      s_scl_drop |-> (hi_cnt_r >= HIGH_MIN))
      else $error("SCL high phase too short");
   master_ack_a: assert property (@(posedge link_clk_in) disable iff (link_rst) // RL20
      s_ack_drive |-> sda_oe_r)
      else $error("master did not acknowledge read byte");
   dir_write_a: assert property (@(posedge link_clk_in) disable iff (link_rst) // RL17
      ((lst_r == L_BIT) && byte_num_r == BYTE_ADDR && bit_cnt_r == 4'h7 && phase_r != 2'h0) |-> sda_oe_r)
      else $error("first address byte direction not zero");
   dir_read_a: assert property (@(posedge link_clk_in) disable iff (link_rst) // RL19
      ((lst_r == L_BIT) && !is_write && byte_num_r == BYTE_RADDR && bit_cnt_r == 4'h7 && phase_r != 2'h0)
      |-> !sda_oe_r)
      else $error("read address direction not one");
endmodule : serial_bus_master

// ---- verification/eeprom_slave_model.sv ----
// Behavioural two-wire EEPROM slave with an open-drain data pin
`timescale 1ns/10ps
module eeprom_slave_model #(
   parameter logic [6:0] DEV_ADDR = 7'h50
) (
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_oe_out
);
   logic [7:0] mem [0:255];
   logic [7:0] sh;
   logic [7:0] ptr;
   int         bitn;
   int         byten;
   logic       rd;
   logic       act;
   // Byte i holds i with bit 7 set (80h OR i), offset 00h holds the do-not-load flag
   initial
   begin
      for (int i = 0; i < 256; i++) mem[i] = 8'h80 | 8'(i);
      mem[0] = 8'hFF;
      sda_oe_out = 1'b0;
      act = 1'b0;
   end
   // Start or repeated start restarts the byte count
   always @(negedge sda_in)
   begin
      if (scl_in)
      begin
         bitn = -1;
         byten = 0;
         rd = 1'b0;
         act = 1'b1;
      end
   end
   // Stop releases the data line
   always @(posedge sda_in)
   begin
      if (scl_in)
      begin
         act = 1'b0;
         sda_oe_out = 1'b0;
      end
   end
   // Shift received bits while SCL is high
   always @(posedge scl_in)
   begin
      if (act && !rd && bitn >= 0 && bitn < 8) sh = {sh[6:0], sda_in};
   end
   // Data pin changes only while SCL is low, and only pulls low or releases
   always @(negedge scl_in)
   begin
      if (act)
      begin
         bitn = bitn + 1;
         if (bitn == 8 && !rd)
         begin
            if (byten == 0 && sh[7:1] != DEV_ADDR) act = 1'b0;
            else
            begin
               sda_oe_out = 1'b1;
               if (byten == 0) rd = sh[0];
               else if (byten == 1) ptr = sh;
               else
               begin
                  mem[ptr] = sh;
                  ptr = ptr + 8'h01;
               end
            end
         end
         else if (bitn == 8) sda_oe_out = 1'b0;
         else if (bitn == 9)
         begin
            bitn = 0;
            byten = byten + 1;
            sda_oe_out = 1'b0;
            if (rd)
            begin
               sh = mem[ptr];
               ptr = ptr + 8'h01;
            end
         end
         if (rd && bitn < 8) sda_oe_out = ~sh[7 - bitn];
      end
   end
endmodule : eeprom_slave_model

// ---- verification/serial_bus_master_test.sv ----
// Self-checking bench for the two-wire serial bus master
`timescale 1ns/10ps
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module serial_bus_master_test;
   logic        mclk, link_clk, rst, pz, po, start, rdsel, dclr, eclr;
   logic [6:0]  addr;
   logic [7:0]  idx, wdata, rdata, loff;
   logic        scl_oe, sda_oe, slv_oe, rvalid, busy, err, det, lvalid, scl_lv, sda_lv;
   logic [31:0] ldata;
   wire logic   scl = ~scl_oe;
   wire logic   sda = ~(sda_oe | slv_oe);
   int          n_fail = 0, comparisons = 0, n_load = 0;
   realtime     last_t = 0, min_p = 1.0e9;
   serial_bus_master serial_bus_master_inst (.mclk_in(mclk), .rst_in(rst), .link_clk_in(link_clk),
      .power_switch_ctrl_zero_in(pz), .power_switch_ctrl_one_in(po),
      .multifunction_pin_four_in(scl), .multifunction_pin_four_out(scl_lv), .multifunction_pin_four_oe_out(scl_oe),
      .multifunction_pin_one_in(sda), .multifunction_pin_one_out(sda_lv), .multifunction_pin_one_oe_out(sda_oe),
      .sw_start_in(start), .sw_slave_addr_in(addr), .sw_read_in(rdsel), .sw_index_in(idx),
      .sw_wdata_in(wdata), .detect_clear_in(dclr), .error_clear_in(eclr), .sw_rdata_out(rdata),
      .rdata_valid_out(rvalid), .busy_out(busy), .error_out(err), .bus_detect_flag_out(det),
      .load_valid_out(lvalid), .load_offset_out(loff), .load_data_out(ldata));
   eeprom_slave_model eeprom_slave_model_inst (.scl_in(scl), .sda_in(sda), .sda_oe_out(slv_oe));
   // Clocks: 25 ns controller clock, 6 ns link clock with a phase offset
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      link_clk = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   // Monitors: loader pulses and shortest SCL period
   always @(posedge mclk) if (lvalid === 1'b1) n_load++;
   always @(posedge scl)
   begin
      if (last_t > 0 && $realtime - last_t < min_p) min_p = $realtime - last_t;
      last_t = $realtime;
   end
   task automatic final_report;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   task automatic do_reset(input logic p);
      @(posedge mclk);
      #2;
      rst = 1'b1;
      pz = p;
      po = p;
      repeat (5) @(posedge mclk);
      #2;
      rst = 1'b0;
   endtask : do_reset
   task automatic sw_xfer(input logic [6:0] a, input logic r, input logic [7:0] i, input logic [7:0] d);
      @(posedge mclk);
      #2;
      {addr, rdsel, idx, wdata, start} = {a, r, i, d, 1'b1};
      @(posedge mclk);
      #2;
      start = 1'b0;
   endtask : sw_xfer
   task automatic pulse(ref logic s);
      @(posedge mclk);
      #2;
      s = 1'b1;
      @(posedge mclk);
      #2;
      s = 1'b0;
      @(posedge mclk);
      #1;
   endtask : pulse
   task automatic wait_idle;
      int n;
      n = 0;
      repeat (2) @(posedge mclk);
      #1;
      while (busy !== 1'b0 && n < 40000)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHECK("busy", 1'b0, busy)
   endtask : wait_idle
   // Watchdog cuts a hang short
   initial
   begin
      repeat (98000) @(posedge mclk);
      n_fail++;
      final_report();
   end
   // Test sequence
   initial
   begin
      {rst, pz, po, start, rdsel, dclr, eclr} = 7'h40;
      {addr, idx, wdata} = '0;
      do_reset(1'b0);
      repeat (20) @(posedge mclk);
      #1;
      `CHECK("detect_absent", 1'b0, det)
      sw_xfer(7'h50, 1'b0, 8'h10, 8'h5A);
      repeat (3) @(posedge mclk);
      #1;
      `CHECK("busy_absent", 1'b0, busy)
      do_reset(1'b1);
      wait_idle();
      `CHECK("detect", 1'b1, det)
      `CHECK("load_pulses", 0, n_load)
      `CHECK("load_off", 8'h00, loff)
      `CHECK("load_data", 32'h0000_0000, ldata)
      `CHECK("loader_err", 1'b0, err)
      `CHECK("scl_idle", 1'b1, scl)
      pulse(dclr);
      `CHECK("detect_clr", 1'b0, det)
      sw_xfer(7'h50, 1'b0, 8'h10, 8'hC5);
      wait_idle();
      `CHECK("wr_mem", 8'hC5, eeprom_slave_model_inst.mem[8'h10])
      `CHECK("wr_err", 1'b0, err)
      sw_xfer(7'h50, 1'b1, 8'h10, 8'h00);
      wait_idle();
      `CHECK("rd_valid", 1'b1, rvalid)
      `CHECK("rd_data", 8'hC5, rdata)
      sw_xfer(7'h50, 1'b1, 8'h11, 8'h00);
      wait_idle();
      `CHECK("rd_index", 8'h91, rdata)
      sw_xfer(7'h22, 1'b0, 8'h10, 8'h3C);
      wait_idle();
      `CHECK("nack_err", 1'b1, err)
      `CHECK("nack_mem", 8'hC5, eeprom_slave_model_inst.mem[8'h10])
      pulse(eclr);
      `CHECK("err_clr", 1'b0, err)
      `CHECK("pin_levels", 2'b00, {scl_lv, sda_lv})
      `CHECK("scl_slow", 1'b1, min_p >= 10000.0)
      `CHECK("scl_near", 1'b1, min_p <= 10100.0)
      final_report();
   end
endmodule : serial_bus_master_test
